// ### verilog/mda_defines.vh
// Operation
// - with on-chip memory on, moves to 0000h-03FFh use the internal SRAM
// - with field 01, move addresses above 03FFh go to the bus
// - with on-chip memory off, every move 0000h-FFFFh goes external
// - enable field: 00 all external (reset), 01 SRAM low, 10 reserved
// - field 11: SRAM low, lock status at FFFCh, no external access else
// - lock status bits 2-0 read 1 per programmed lock bit, read-only
// - enable field is bits 1:0 of register C4h, applied dynamically
// - changing the enable field never alters SRAM contents
// - internal SRAM moves always take two machine cycles
// - external move takes stretch plus two machine cycles
// - stretch resets to 1, giving three-cycle external moves
// - stretch lives in bits 2:0 of register 8Eh
// - strobe is 2 clocks at stretch 0, else 4 clocks per stretch unit
// - nonzero stretch adds one clock of address setup and of hold
// - stretch affects data moves only, never program fetch timing
// - two 16-bit pointers: 82h/83h and 84h/85h, low then high byte
// - bit 0 of 86h selects active pointer; other bits read 0
// - pointer use, load and increment act on the selected pointer
`ifndef MDA_DEFINES_VH
`define MDA_DEFINES_VH

// register offsets
`define MDA_OFS_PTR0_LO   8'h82
`define MDA_OFS_PTR0_HI   8'h83
`define MDA_OFS_PTR1_LO   8'h84
`define MDA_OFS_PTR1_HI   8'h85
`define MDA_OFS_PTR_SEL   8'h86
`define MDA_OFS_CLK_CTRL  8'h8E
`define MDA_OFS_PWR_CTRL  8'hC4

// field positions
`define MDA_STRETCH_MSB   2
`define MDA_STRETCH_LSB   0
`define MDA_DME_MSB       1
`define MDA_DME_LSB       0
`define MDA_PTR_SEL_BIT   0

// reset values
`define MDA_CLK_CTRL_RST  8'h01
`define MDA_PWR_CTRL_RST  8'h40
`define MDA_PTR_RST       16'h0000

// enable field codes
`define MDA_DME_EXT       2'b00
`define MDA_DME_LOW       2'b01
`define MDA_DME_RSVD      2'b10
`define MDA_DME_LOCKED    2'b11

// address map
`define MDA_SRAM_TOP      16'h03FF
`define MDA_LOCK_ADDR     16'hFFFC
`define MDA_NOACC_RDATA   8'hFF

// timing counts in clocks, MDA_BASE_MC in machine cycles, sized to the cycle counter width
`define MDA_MC_CLOCKS     6'h04
`define MDA_BASE_MC       6'h02
`define MDA_ALE_CLOCKS    6'h02
`define MDA_WDATA_START   6'h03
`define MDA_STB_START0    6'h04
`define MDA_STB_WIDTH0    6'h02
`define MDA_STB_PER_UNIT  6'h04
`define MDA_SETUP_EXTRA   6'h01
`define MDA_HOLD0         6'h01
`define MDA_CNT_W         6

`endif

// ### verilog/mda_sram.v
`timescale 1ns/1ps
`include "mda_defines.vh"

module mda_sram #(
	parameter AW = 10,
	parameter DW = 8
) (
	input  wire          clk,     // core clock
	input  wire          we,      // write strobe
	input  wire [AW-1:0] addr,    // word address
	input  wire [DW-1:0] wdata,   // write data
	output reg  [DW-1:0] rdata    // read data, one clock late
);

	// no reset on purpose: contents survive mapping changes
	reg [DW-1:0] mem [0:(1<<AW)-1];

	// synchronous read-before-write port
	always @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end

endmodule

// ### verilog/mda_ext_cycle.v
`timescale 1ns/1ps
`include "mda_defines.vh"

module mda_ext_cycle (
	input  wire       core_clk,     // core clock
	input  wire       rst_n,        // sync reset, active low
	input  wire       start,        // begin an external cycle
	input  wire       write,        // 1 write, 0 read
	input  wire [15:0] addr,        // bus address
	input  wire [7:0] wdata,        // write data
	input  wire [2:0] stretch,      // stretch value
	input  wire [7:0] ad_sync,      // synchronised low bus input
	output reg        ale,          // address latch enable
	output reg        rd_n,         // read strobe, active low
	output reg        wr_n,         // write strobe, active low
	output reg  [7:0] ad_out,       // low bus drive value
	output reg        ad_oe,        // low bus drive enable
	output reg  [7:0] addr_hi,      // high address byte
	output reg        addr_hi_oe,   // high address drive enable
	output reg  [7:0] rdata,        // captured read data
	output reg        done          // one-clock end pulse
);

	reg                  act_reg;
	reg [`MDA_CNT_W-1:0] cnt_reg;
	reg [2:0]            s_reg;
	reg                  wr_reg;
	reg [15:0]           a_reg;
	reg [7:0]            d_reg;
	reg                  n_act;
	reg [`MDA_CNT_W-1:0] n_cnt;
	reg [2:0]            n_s;
	reg [`MDA_CNT_W-1:0] last_c;
	reg [`MDA_CNT_W-1:0] stb_beg;
	reg [`MDA_CNT_W-1:0] stb_end;
	reg [`MDA_CNT_W-1:0] hold_end;
	wire [`MDA_CNT_W-1:0] cur_last;

	// cycle length and strobe window for the stretch of this cycle
	always @* begin
		n_s = start ? stretch : s_reg;
		n_act = start | (act_reg & (cnt_reg != cur_last));
		n_cnt = start ? {`MDA_CNT_W{1'b0}} : cnt_reg + 1'b1;
		last_c = (n_s + `MDA_BASE_MC) * `MDA_MC_CLOCKS - 6'h01;
		if (n_s == 3'h0) begin
			stb_beg = `MDA_STB_START0;
			stb_end = `MDA_STB_START0 + `MDA_STB_WIDTH0;
			hold_end = stb_end + `MDA_HOLD0;
		end else begin
			// one more clock of setup and hold beside the wider strobe
			stb_beg = `MDA_STB_START0 + `MDA_SETUP_EXTRA;
			stb_end = stb_beg + n_s * `MDA_STB_PER_UNIT;
			hold_end = stb_end + `MDA_HOLD0 + `MDA_SETUP_EXTRA;
		end
	end

	assign cur_last = (s_reg + `MDA_BASE_MC) * `MDA_MC_CLOCKS - 6'h01;

	// pin registers follow the next count so pins line up with it
	always @(posedge core_clk) begin
		if (!rst_n) begin
			act_reg <= 1'b0;
			cnt_reg <= {`MDA_CNT_W{1'b0}};
			s_reg <= 3'h0;
			wr_reg <= 1'b0;
			a_reg <= 16'h0000;
			d_reg <= 8'h00;
			ale <= 1'b0;
			rd_n <= 1'b1;
			wr_n <= 1'b1;
			ad_out <= 8'h00;
			ad_oe <= 1'b0;
			addr_hi <= 8'h00;
			addr_hi_oe <= 1'b0;
			rdata <= 8'h00;
			done <= 1'b0;
		end else begin
			act_reg <= n_act;
			cnt_reg <= n_act ? n_cnt : {`MDA_CNT_W{1'b0}};
			s_reg <= n_s;
			if (start) begin
				wr_reg <= write;
				a_reg <= addr;
				d_reg <= wdata;
			end
			ale <= n_act & (n_cnt < `MDA_ALE_CLOCKS);
			rd_n <= ~(n_act & ~(start ? write : wr_reg) &
				(n_cnt >= stb_beg) & (n_cnt < stb_end));
			wr_n <= ~(n_act & (start ? write : wr_reg) &
				(n_cnt >= stb_beg) & (n_cnt < stb_end));
			addr_hi <= start ? addr[15:8] : a_reg[15:8];
			addr_hi_oe <= n_act;
			if (n_act & (n_cnt < `MDA_ALE_CLOCKS)) begin
				ad_out <= start ? addr[7:0] : a_reg[7:0];
				ad_oe <= 1'b1;
			end else if (n_act & wr_reg & (n_cnt >= `MDA_WDATA_START) &
				(n_cnt < hold_end)) begin
				ad_out <= d_reg;
				ad_oe <= 1'b1;
			end else begin
				ad_out <= 8'h00;
				ad_oe <= 1'b0;
			end
			// sampled two clocks after the strobe's last clock: sync delay
			if (act_reg & ~wr_reg & (cnt_reg == stb_end + 1'b1)) begin
				rdata <= ad_sync;
			end
			done <= act_reg & (cnt_reg == cur_last);
		end
	end

endmodule

// ### verilog/mda_top.v
`timescale 1ns/1ps
`include "mda_defines.vh"

module mda_top (
	input  wire        core_clk,       // 10 MHz core clock
	input  wire        rst_n,          // sync reset, active low
	input  wire [7:0]  sfr_addr,       // register address
	input  wire        sfr_wr,         // register write strobe
	input  wire        sfr_rd,         // register read strobe
	input  wire [7:0]  sfr_wdata,      // register write data
	output reg  [7:0]  sfr_rdata,      // register read data
	input  wire        xm_req,         // data-move request pulse
	input  wire        xm_write,       // 1 write, 0 read
	input  wire        xm_use_ptr,     // address from data pointer
	input  wire [15:0] xm_addr,        // address when not from pointer
	input  wire [7:0]  xm_wdata,       // move write data
	output reg  [7:0]  xm_rdata,       // move read data
	output reg         xm_done,        // move finished pulse
	output wire        xm_busy,        // move in progress
	input  wire        ptr_inc,        // increment selected pointer
	input  wire        ptr_load,       // load selected pointer
	input  wire [15:0] ptr_load_val,   // pointer load value
	output wire [15:0] data_pointer,   // selected pointer value
	input  wire [2:0]  security_lock_bits, // lock bit straps
	input  wire [7:0]  ext_ad_in,      // low bus pins, input
	output wire [7:0]  ext_ad_out,     // low bus pins, output
	output wire        ext_ad_oe,      // low bus drive enable
	output wire [7:0]  ext_addr_hi,    // high address pins
	output wire        ext_addr_hi_oe, // high address drive enable
	output wire        ext_ale,        // address latch enable
	output wire        ext_rd_n,       // read strobe, active low
	output wire        ext_wr_n        // write strobe, active low
);

	localparam ST_IDLE = 2'b00;
	localparam ST_INT  = 2'b01;
	localparam ST_EXT  = 2'b10;
	localparam ST_NONE = 2'b11;
	localparam [5:0] INT_CLOCKS = `MDA_BASE_MC * `MDA_MC_CLOCKS;
	localparam [3:0] INT_LAST = INT_CLOCKS[3:0] - 4'h1;

	reg [15:0] ptr_a_reg;
	reg [15:0] ptr_b_reg;
	reg        sel_reg;
	reg [7:0]  clk_ctrl_reg;
	reg [7:0]  pwr_ctrl_reg;
	reg [1:0]  state_reg;
	reg [1:0]  state_next;
	reg [3:0]  icnt_reg;
	reg [15:0] mv_addr_reg;
	reg [7:0]  mv_wdata_reg;
	reg        mv_write_reg;
	reg [7:0]  none_rdata_reg;
	reg [7:0]  ad_meta_reg;
	reg [7:0]  ad_sync_reg;
	reg [2:0]  lock_meta_reg;
	reg [2:0]  lock_sync_reg;
	reg [7:0]  rd_mux;
	wire [15:0] mv_addr;
	wire [1:0]  dme;
	wire [2:0]  stretch;
	wire        accept;
	wire        in_sram;
	wire        go_int;
	wire        go_ext;
	wire        ext_start;
	wire [7:0]  ram_rdata;
	wire [7:0]  ext_rdata;
	wire        ext_done;
	wire        int_finish;
	wire        is_lock_rd;

	assign dme = pwr_ctrl_reg[`MDA_DME_MSB:`MDA_DME_LSB];
	assign stretch = clk_ctrl_reg[`MDA_STRETCH_MSB:`MDA_STRETCH_LSB];

	// the select bit picks which pointer every pointer user sees
	assign data_pointer = sel_reg ? ptr_b_reg : ptr_a_reg;
	assign mv_addr = xm_use_ptr ? data_pointer : xm_addr;

	// pins and straps come from outside; two flops before any use
	always @(posedge core_clk) begin
		if (!rst_n) begin
			ad_meta_reg <= 8'h00;
			ad_sync_reg <= 8'h00;
			lock_meta_reg <= 3'h0;
			lock_sync_reg <= 3'h0;
		end else begin
			ad_meta_reg <= ext_ad_in;
			ad_sync_reg <= ad_meta_reg;
			lock_meta_reg <= security_lock_bits;
			lock_sync_reg <= lock_meta_reg;
		end
	end

	// address decode uses the field as it stands when the move is taken,
	// so a field change simply applies to the next move
	assign accept = xm_req & (state_reg == ST_IDLE);
	assign in_sram = (mv_addr <= `MDA_SRAM_TOP) &
		((dme == `MDA_DME_LOW) | (dme == `MDA_DME_LOCKED));
	assign go_int = accept & in_sram;
	// field 11 blocks the bus above the SRAM; 00 and 10 send all out
	assign go_ext = accept & ~in_sram & (dme != `MDA_DME_LOCKED);
	assign ext_start = go_ext;
	assign is_lock_rd = ~xm_write & (mv_addr == `MDA_LOCK_ADDR);

	// move sequencer state
	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (go_int) begin
					state_next = ST_INT;
				end else if (go_ext) begin
					state_next = ST_EXT;
				end else if (accept) begin
					state_next = ST_NONE;
				end
			end
			ST_INT: begin
				if (icnt_reg == INT_LAST) begin
					state_next = ST_IDLE;
				end
			end
			ST_NONE: begin
				if (icnt_reg == INT_LAST) begin
					state_next = ST_IDLE;
				end
			end
			ST_EXT: begin
				if (ext_done) begin
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	assign xm_busy = (state_reg != ST_IDLE);
	// internal and no-access moves last two machine cycles, any stretch
	assign int_finish = ((state_reg == ST_INT) | (state_reg == ST_NONE)) &
		(icnt_reg == INT_LAST);

	// capture the move and count the fixed-length paths
	always @(posedge core_clk) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			icnt_reg <= 4'h0;
			mv_addr_reg <= 16'h0000;
			mv_wdata_reg <= 8'h00;
			mv_write_reg <= 1'b0;
			none_rdata_reg <= 8'h00;
			xm_done <= 1'b0;
			xm_rdata <= 8'h00;
		end else begin
			state_reg <= state_next;
			if (accept) begin
				icnt_reg <= 4'h0;
				mv_addr_reg <= mv_addr;
				mv_wdata_reg <= xm_wdata;
				mv_write_reg <= xm_write;
				// lock status: bit per programmed lock, upper bits zero
				none_rdata_reg <= is_lock_rd ?
					{5'h00, lock_sync_reg} : `MDA_NOACC_RDATA;
			end else if (state_reg != ST_IDLE) begin
				icnt_reg <= icnt_reg + 4'h1;
			end
			xm_done <= int_finish | ext_done;
			if (int_finish & ~mv_write_reg) begin
				xm_rdata <= (state_reg == ST_INT) ?
					ram_rdata : none_rdata_reg;
			end else if (ext_done & ~mv_write_reg) begin
				xm_rdata <= ext_rdata;
			end
		end
	end

	// write once at the first clock of an internal move; the read port
	// keeps the word valid from the second clock of the move to its end
	mda_sram #(
		.AW(10),
		.DW(8)
	) u_sram (
		.clk   (core_clk),
		.we    ((state_reg == ST_INT) & (icnt_reg == 4'h0) & mv_write_reg),
		.addr  (mv_addr_reg[9:0]),
		.wdata (mv_wdata_reg),
		.rdata (ram_rdata)
	);

	// only this unit touches the bus pins, and it starts only on an
	// external route, so internal and blocked moves leave the bus idle
	mda_ext_cycle u_ext (
		.core_clk   (core_clk),
		.rst_n      (rst_n),
		.start      (ext_start),
		.write      (xm_write),
		.addr       (mv_addr),
		.wdata      (xm_wdata),
		.stretch    (stretch),
		.ad_sync    (ad_sync_reg),
		.ale        (ext_ale),
		.rd_n       (ext_rd_n),
		.wr_n       (ext_wr_n),
		.ad_out     (ext_ad_out),
		.ad_oe      (ext_ad_oe),
		.addr_hi    (ext_addr_hi),
		.addr_hi_oe (ext_addr_hi_oe),
		.rdata      (ext_rdata),
		.done       (ext_done)
	);

	// register writes; a register write beats a same-cycle pointer op
	always @(posedge core_clk) begin
		if (!rst_n) begin
			ptr_a_reg <= `MDA_PTR_RST;
			ptr_b_reg <= `MDA_PTR_RST;
			sel_reg <= 1'b0;
			clk_ctrl_reg <= `MDA_CLK_CTRL_RST;
			pwr_ctrl_reg <= `MDA_PWR_CTRL_RST;
		end else begin
			if (sfr_wr) begin
				case (sfr_addr)
					`MDA_OFS_PTR0_LO: ptr_a_reg[7:0] <= sfr_wdata;
					`MDA_OFS_PTR0_HI: ptr_a_reg[15:8] <= sfr_wdata;
					`MDA_OFS_PTR1_LO: ptr_b_reg[7:0] <= sfr_wdata;
					`MDA_OFS_PTR1_HI: ptr_b_reg[15:8] <= sfr_wdata;
					`MDA_OFS_PTR_SEL: begin
						sel_reg <= sfr_wdata[`MDA_PTR_SEL_BIT];
					end
					`MDA_OFS_CLK_CTRL: clk_ctrl_reg <= sfr_wdata;
					// field change never touches SRAM contents
					`MDA_OFS_PWR_CTRL: pwr_ctrl_reg <= sfr_wdata;
					default: begin
					end
				endcase
			end else if (ptr_load) begin
				if (sel_reg) begin
					ptr_b_reg <= ptr_load_val;
				end else begin
					ptr_a_reg <= ptr_load_val;
				end
			end else if (ptr_inc) begin
				if (sel_reg) begin
					ptr_b_reg <= ptr_b_reg + 16'h0001;
				end else begin
					ptr_a_reg <= ptr_a_reg + 16'h0001;
				end
			end
		end
	end

	// read mux; unused select bits read zero, unmapped reads zero
	always @* begin
		case (sfr_addr)
			`MDA_OFS_PTR0_LO:  rd_mux = ptr_a_reg[7:0];
			`MDA_OFS_PTR0_HI:  rd_mux = ptr_a_reg[15:8];
			`MDA_OFS_PTR1_LO:  rd_mux = ptr_b_reg[7:0];
			`MDA_OFS_PTR1_HI:  rd_mux = ptr_b_reg[15:8];
			`MDA_OFS_PTR_SEL:  rd_mux = {7'h00, sel_reg};
			`MDA_OFS_CLK_CTRL: rd_mux = clk_ctrl_reg;
			`MDA_OFS_PWR_CTRL: rd_mux = pwr_ctrl_reg;
			default:           rd_mux = 8'h00;
		endcase
	end

	// read data registered; a same-cycle write is seen on the next read
	always @(posedge core_clk) begin
		if (!rst_n) begin
			sfr_rdata <= 8'h00;
		end else if (sfr_rd) begin
			sfr_rdata <= rd_mux;
		end
	end

endmodule

// ### testbench/mda_assertions.sv
`timescale 1ns/1ps
`include "mda_defines.vh"

module mda_assertions (
	input wire        core_clk,       // clock
	input wire        rst_n,          // reset
	input wire [7:0]  sfr_addr,       // reg address
	input wire        sfr_wr,         // reg write
	input wire        sfr_rd,         // reg read
	input wire [7:0]  sfr_wdata,      // reg data
	input wire [7:0]  sfr_rdata,      // reg read data
	input wire        xm_req,         // move request
	input wire        xm_use_ptr,     // pointer address
	input wire [15:0] xm_addr,        // move address
	input wire        xm_done,        // move done
	input wire        xm_busy,        // move busy
	input wire        ptr_inc,        // pointer step
	input wire        ptr_load,       // pointer load
	input wire [15:0] data_pointer,   // active pointer
	input wire        ext_ad_oe,      // low bus enable
	input wire        ext_addr_hi_oe, // high bus enable
	input wire        ext_ale,        // latch enable
	input wire        ext_rd_n,       // read strobe
	input wire        ext_wr_n        // write strobe
);
	reg  [2:0]  st_reg, lat_reg;
	reg  [1:0]  dme_reg;
	reg  [5:0]  cnt_reg, exp_reg, stb_reg;
	reg         act_reg;
	wire [15:0] ea = xm_use_ptr ? data_pointer : xm_addr;
	wire        acc = xm_req && !xm_busy;
	// field 10 falls back to all external, so bit 0 alone maps SRAM in
	wire        ext = !dme_reg[0] || (dme_reg == 2'h1 && ea > `MDA_SRAM_TOP);
	wire        stb = !ext_rd_n || !ext_wr_n;
	wire        quiet = ext_rd_n && ext_wr_n && !ext_ale && !ext_ad_oe
		&& !ext_addr_hi_oe;

	// shadow the fields and time each move from its accept edge
	always @(posedge core_clk) begin
		if (!rst_n) begin
			st_reg <= 3'h1;
			lat_reg <= 3'h1;
			dme_reg <= 2'h0;
			act_reg <= 1'h0;
			cnt_reg <= 6'h00;
			exp_reg <= 6'h00;
		end else begin
			if (sfr_wr && sfr_addr == `MDA_OFS_CLK_CTRL)
				st_reg <= sfr_wdata[2:0];
			if (sfr_wr && sfr_addr == `MDA_OFS_PWR_CTRL)
				dme_reg <= sfr_wdata[1:0];
			if (acc) begin
				act_reg <= 1'h1;
				cnt_reg <= 6'h01;
				lat_reg <= st_reg;
				exp_reg <= ext ? ({3'h0, st_reg} + 6'h02) * 6'h04 + 6'h02 : 6'h09;
			end else if (xm_done)
				act_reg <= 1'h0;
			else if (act_reg)
				cnt_reg <= cnt_reg + 6'h01;
		end
		stb_reg <= stb ? stb_reg + 6'h01 : 6'h00;
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	sequence s_quiet; quiet [*8]; endsequence
	sequence s_setup; !stb [*3] ##1 stb; endsequence
	property p_no_bus; acc && !ext |=> s_quiet; endproperty
	property p_ext_go; acc && ext |-> ##[1:3] ext_ale; endproperty
	property p_due; act_reg && cnt_reg == exp_reg |-> xm_done; endproperty
	property p_early; xm_done |-> act_reg && cnt_reg == exp_reg; endproperty
	property p_width;
		$fell(stb) |-> stb_reg == (lat_reg == 3'h0 ? 6'h02 : {1'h0, lat_reg, 2'h0});
	endproperty
	property p_setup; $fell(ext_ale) && lat_reg != 3'h0 |-> s_setup; endproperty
	property p_ptr;
		ptr_inc && !ptr_load && !sfr_wr |=>
			data_pointer == $past(data_pointer) + 16'h0001;
	endproperty
	property p_sel;
		sfr_rd && sfr_addr == `MDA_OFS_PTR_SEL |=> sfr_rdata[7:1] == 7'h00;
	endproperty

	a_no_bus: assert property (p_no_bus)
		else $error("bus active on a move kept inside");
	a_ext_go: assert property (p_ext_go)
		else $error("external move did not start");
	a_due: assert property (p_due)
		else $error("move not done on time");
	a_early: assert property (p_early)
		else $error("move done at wrong time");
	a_width: assert property (p_width)
		else $error("strobe width wrong");
	a_setup: assert property (p_setup)
		else $error("address setup not stretched");
	a_ptr: assert property (p_ptr)
		else $error("pointer step wrong");
	a_sel: assert property (p_sel)
		else $error("select upper bits not zero");
endmodule

bind mda_top mda_assertions u_chk (.core_clk, .rst_n, .sfr_addr, .sfr_wr,
	.sfr_rd, .sfr_wdata, .sfr_rdata, .xm_req, .xm_use_ptr, .xm_addr, .xm_done,
	.xm_busy, .ptr_inc, .ptr_load, .data_pointer, .ext_ad_oe, .ext_addr_hi_oe,
	.ext_ale, .ext_rd_n, .ext_wr_n);

// ### testbench/mda_ext_mem.sv
`timescale 1ns/1ps

module mda_ext_mem (
	input  wire       core_clk,    // clock
	input  wire       ext_ale,     // latch enable
	input  wire       ext_rd_n,    // read strobe
	input  wire       ext_wr_n,    // write strobe
	input  wire [7:0] ext_ad_out,  // device drive value
	input  wire       ext_ad_oe,   // device drive enable
	input  wire [7:0] ext_addr_hi, // high address
	output wire [7:0] ext_ad_in    // resolved low bus
);
	reg  [7:0]  mem [0:65535];
	reg  [15:0] addr_reg = 16'h0000;
	reg  [7:0]  last_reg = 8'h00;
	reg  [1:0]  hold_reg = 2'h0;
	wire        drive = !ext_rd_n || hold_reg != 2'h0;
	integer     j;

	initial for (j = 0; j < 65536; j = j + 1) mem[j] = 8'h00;
	// released pins show a changing pattern, never a stale byte
	assign ext_ad_in = ext_ad_oe ? ext_ad_out :
		drive ? mem[addr_reg] : ~last_reg;
	// read data stays two clocks after the strobe, then is let go
	always @(posedge core_clk) begin
		if (ext_ale)
			addr_reg <= {ext_addr_hi, ext_ad_out};
		if (!ext_wr_n && ext_ad_oe)
			mem[addr_reg] <= ext_ad_out;
		hold_reg <= !ext_rd_n ? 2'h2 : hold_reg != 2'h0 ? hold_reg - 2'h1 : 2'h0;
		last_reg <= ext_ad_in;
	end
endmodule

// ### testbench/test_external_data_move_data_access_unit.sv
`timescale 1ns/1ps
`include "mda_defines.vh"

module test_external_data_move_data_access_unit;
	reg         core_clk = 1'h0, rst_n = 1'h0, sfr_wr = 1'h0, sfr_rd = 1'h0;
	reg         xm_req = 1'h0, xm_write = 1'h0, xm_use_ptr = 1'h0;
	reg         ptr_inc = 1'h0, ptr_load = 1'h0;
	reg  [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, xm_wdata = 8'h00;
	reg  [15:0] xm_addr = 16'h0000, ptr_load_val = 16'h0000;
	reg  [2:0]  security_lock_bits = 3'h5;
	wire [7:0]  sfr_rdata, xm_rdata, ext_ad_in, ext_ad_out, ext_addr_hi;
	wire [15:0] data_pointer;
	wire        xm_done, xm_busy, ext_ad_oe, ext_addr_hi_oe;
	wire        ext_ale, ext_rd_n, ext_wr_n;
	integer     errors = 0, compares = 0, i;

	mda_top DUT (.core_clk, .rst_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
		.sfr_rdata, .xm_req, .xm_write, .xm_use_ptr, .xm_addr, .xm_wdata,
		.xm_rdata, .xm_done, .xm_busy, .ptr_inc, .ptr_load, .ptr_load_val,
		.data_pointer, .security_lock_bits, .ext_ad_in, .ext_ad_out, .ext_ad_oe,
		.ext_addr_hi, .ext_addr_hi_oe, .ext_ale, .ext_rd_n, .ext_wr_n);
	mda_ext_mem u_mem (.core_clk, .ext_ale, .ext_rd_n, .ext_wr_n, .ext_ad_out,
		.ext_ad_oe, .ext_addr_hi, .ext_ad_in);

	always #50 core_clk = ~core_clk;

	task stop_test;
		begin
			$display("compares %0d errors %0d", compares, errors);
			if (errors == 0 && compares > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask
	task check(input [63:0] name, input [15:0] exp, input [15:0] got);
		begin
			compares = compares + 1;
			if (got !== exp) begin
				errors = errors + 1;
				$display("Error %0s expected %h seen %h", name, exp, got);
			end
		end
	endtask
	// one register access; read data lands at the strobe's own edge
	task sfr_io(input w, input [7:0] a, input [7:0] d);
		begin
			@(posedge core_clk);
			sfr_wr <= w;
			sfr_rd <= !w;
			sfr_addr <= a;
			sfr_wdata <= d;
			@(posedge core_clk);
			sfr_wr <= 1'h0;
			sfr_rd <= 1'h0;
			#1;
		end
	endtask
	task sfr_chk(input [7:0] a, input [7:0] exp);
		begin
			sfr_io(1'h0, a, 8'h00);
			check("register", {8'h00, exp}, {8'h00, sfr_rdata});
		end
	endtask
	task ptr_op(input inc, input ld, input [15:0] v);
		begin
			@(posedge core_clk);
			ptr_inc <= inc;
			ptr_load <= ld;
			ptr_load_val <= v;
			@(posedge core_clk);
			ptr_inc <= 1'h0;
			ptr_load <= 1'h0;
			#1;
		end
	endtask
	// a data move; counts clocks from the accept edge to the done pulse
	task move(input w, input p, input [15:0] a, input [7:0] d,
		input [5:0] cyc, input [7:0] exp);
		integer n;
		begin
			@(posedge core_clk);
			xm_req <= 1'h1;
			xm_write <= w;
			xm_use_ptr <= p;
			xm_addr <= a;
			xm_wdata <= d;
			@(posedge core_clk);
			xm_req <= 1'h0;
			// done raised at edge n is seen 1 ns after edge n; the accept edge is edge 1
			n = 1;
			while (xm_done !== 1'h1 && n < 60) begin
				@(posedge core_clk);
				#1;
				n = n + 1;
			end
			if (n == 60) begin
				errors = errors + 1;
				stop_test;
			end
			check("cycles", {10'h000, cyc}, n[15:0]);
			if (!w)
				check("movedata", {8'h00, exp}, {8'h00, xm_rdata});
		end
	endtask
	function [5:0] xc(input [2:0] s);
		xc = ({3'h0, s} + 6'h02) * 6'h04 + 6'h02;
	endfunction

	initial begin
		repeat (4) @(posedge core_clk);
		rst_n <= 1'h1;
		repeat (3) @(posedge core_clk);
		sfr_chk(`MDA_OFS_CLK_CTRL, 8'h01);
		sfr_chk(`MDA_OFS_PWR_CTRL, 8'h40);
		for (i = 8'h82; i < 8'h87; i = i + 1) sfr_chk(i[7:0], 8'h00);
		sfr_chk(8'h90, 8'h00);
		$display("test reset done");
		move(1'h1, 1'h0, 16'h0010, 8'hA5, xc(3'h1), 8'h00);
		move(1'h1, 1'h0, 16'h0400, 8'h77, xc(3'h1), 8'h00);
		for (i = 0; i < 8; i = i + 1) begin
			sfr_io(1'h1, `MDA_OFS_CLK_CTRL, i[7:0]);
			sfr_chk(`MDA_OFS_CLK_CTRL, i[7:0]);
			move(1'h0, 1'h0, 16'h0010, 8'h00, xc(i[2:0]), 8'hA5);
		end
		$display("test stretch done");
		sfr_io(1'h1, `MDA_OFS_PWR_CTRL, 8'h41);
		move(1'h1, 1'h0, 16'h0010, 8'h3C, 6'h09, 8'h00);
		move(1'h1, 1'h0, 16'h03FF, 8'h5A, 6'h09, 8'h00);
		move(1'h0, 1'h0, 16'h03FF, 8'h00, 6'h09, 8'h5A);
		move(1'h0, 1'h0, 16'h0400, 8'h00, xc(3'h7), 8'h77);
		sfr_io(1'h1, `MDA_OFS_PWR_CTRL, 8'h40);
		move(1'h0, 1'h0, 16'h0010, 8'h00, xc(3'h7), 8'hA5);
		sfr_io(1'h1, `MDA_OFS_PWR_CTRL, 8'h42);
		move(1'h0, 1'h0, 16'h03FF, 8'h00, xc(3'h7), 8'h00);
		sfr_io(1'h1, `MDA_OFS_PWR_CTRL, 8'h41);
		move(1'h0, 1'h0, 16'h0010, 8'h00, 6'h09, 8'h3C);
		$display("test mapping done");
		sfr_io(1'h1, `MDA_OFS_PWR_CTRL, 8'h43);
		move(1'h0, 1'h0, 16'hFFFC, 8'h00, 6'h09, 8'h05);
		@(posedge core_clk) security_lock_bits <= 3'h2;
		move(1'h1, 1'h0, 16'hFFFC, 8'hFF, 6'h09, 8'h00);
		move(1'h0, 1'h0, 16'hFFFC, 8'h00, 6'h09, 8'h02);
		move(1'h1, 1'h0, 16'h0500, 8'h11, 6'h09, 8'h00);
		move(1'h0, 1'h0, 16'h0500, 8'h00, 6'h09, 8'hFF);
		move(1'h0, 1'h0, 16'hFFFD, 8'h00, 6'h09, 8'hFF);
		move(1'h0, 1'h0, 16'h0010, 8'h00, 6'h09, 8'h3C);
		sfr_io(1'h1, `MDA_OFS_PWR_CTRL, 8'h41);
		move(1'h0, 1'h0, 16'h0500, 8'h00, xc(3'h7), 8'h00);
		$display("test locked field done");
		sfr_io(1'h1, `MDA_OFS_PTR0_LO, 8'h10);
		sfr_io(1'h1, `MDA_OFS_PTR1_LO, 8'hFF);
		sfr_io(1'h1, `MDA_OFS_PTR1_HI, 8'hFF);
		sfr_io(1'h1, `MDA_OFS_PTR_SEL, 8'hFF);
		sfr_chk(`MDA_OFS_PTR_SEL, 8'h01);
		check("pointer", 16'hFFFF, data_pointer);
		ptr_op(1'h1, 1'h0, 16'h0000);
		check("pointer", 16'h0000, data_pointer);
		sfr_chk(`MDA_OFS_PTR1_HI, 8'h00);
		sfr_io(1'h1, `MDA_OFS_PTR_SEL, 8'h00);
		check("pointer", 16'h0010, data_pointer);
		move(1'h0, 1'h1, 16'h0500, 8'h00, 6'h09, 8'h3C);
		ptr_op(1'h0, 1'h1, 16'h03FF);
		sfr_chk(`MDA_OFS_PTR0_HI, 8'h03);
		move(1'h0, 1'h1, 16'h0010, 8'h00, 6'h09, 8'h5A);
		$display("test pointers done");
		stop_test;
	end
endmodule
